// ==== hdl/pos_params.svh ====
// Register offsets, field positions, reset values and timing counts of the positioner.
`ifndef POS_PARAMS_SVH
`define POS_PARAMS_SVH

// Register byte offsets.
`define ADR_CTRL      8'h00
`define ADR_ARG       8'h04
`define ADR_UPC       8'h08
`define ADR_SPEED     8'h0c
`define ADR_ACCEL     8'h10
`define ADR_JTF       8'h14
`define ADR_JTC       8'h18
`define ADR_VLIM      8'h1c
`define ADR_ALIM      8'h20
`define ADR_EDF       8'h24
`define ADR_FDEST     8'h28
`define ADR_SETP      8'h2c
`define ADR_ACTUAL    8'h30
`define ADR_TERR      8'h34
`define ADR_STATUS    8'h38
`define ADR_QRES      8'h3c
`define ADR_JT        8'h40
`define ADR_CRUISE    8'h44
`define ADR_RDEST     8'h48

// Control bits.
`define CTRL_GO       0
`define CTRL_REL      1
`define CTRL_QRY      2

// Status bits.
`define STS_BUSY      0
`define STS_REFUSED   1
`define STS_REJECT    2
`define STS_QDONE     3

// Reset values.
`define RST_UPC       32'h0000_0100
`define RST_SPEED     32'h0000_0100
`define RST_ACCEL     32'h0000_0010
`define RST_JTF       32'h0000_0028
`define RST_JTC       32'h0000_0190
`define RST_VLIM      32'h0001_0000
`define RST_ALIM      32'h0000_1000
`define RST_EDF       32'h0002_0000

// Timing.
`define CLK_PERIOD_NS   25
`define SERVO_PERIOD_NS 100000
`define SERVO_DIV       ((`SERVO_PERIOD_NS) / (`CLK_PERIOD_NS))

`endif

// ==== hdl/motion_pkg.sv ====
// Types shared by the positioner profile logic.
package motion_pkg;

  typedef logic signed [31:0] fix_t;
  typedef logic signed [47:0] wide_t;

  typedef enum {ST_IDLE, ST_RND, ST_JT, ST_TC, ST_VEL, ST_INV, ST_RUN} plan_state_e;

endpackage : motion_pkg

// ==== hdl/div_if.sv ====
// Request and answer bundle of one sequential divider.
`timescale 1ns/1ps
interface div_if;
  logic        start;
  logic        rnd;
  logic [47:0] dividend;
  logic [31:0] divisor;
  logic [47:0] quotient;
  logic        done;

  modport client (output start, rnd, dividend, divisor, input quotient, done);
  modport server (input start, rnd, dividend, divisor, output quotient, done);
endinterface : div_if

// ==== hdl/div_round.sv ====
// Sequential unsigned divider with optional round-half-up of the quotient.
`timescale 1ns/1ps
module div_round
  import motion_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Divider bundle
  div_if.server    d
);

  logic [47:0] quo_r;
  logic [32:0] rem_r;
  logic [31:0] dvs_r;
  logic [5:0]  cnt_r;
  logic        done_r;
  logic [32:0] shifted;
  logic        ge;
  logic [47:0] loaded;

  // A zero divisor gives an all-ones quotient instead of hanging.
  assign shifted    = {rem_r[31:0], quo_r[47]};
  assign ge         = shifted >= {1'b0, dvs_r};
  assign loaded     = d.dividend + (d.rnd ? {17'h0, d.divisor[31:1]} : 48'h0); // RULE_14
  assign d.quotient = quo_r;
  assign d.done     = done_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      quo_r  <= 48'h0;
      rem_r  <= 33'h0;
      dvs_r  <= 32'h0;
      cnt_r  <= 6'h0;
      done_r <= 1'b0;
    end else if (d.start) begin
      quo_r  <= loaded;
      rem_r  <= 33'h0;
      dvs_r  <= d.divisor;
      cnt_r  <= 6'h30;
      done_r <= 1'b0;
    end else if (cnt_r != 6'h0) begin
      rem_r  <= ge ? shifted - {1'b0, dvs_r} : shifted;
      quo_r  <= {quo_r[46:0], ge};
      cnt_r  <= cnt_r - 6'h1;
      done_r <= (cnt_r == 6'h1);
    end else begin
      done_r <= 1'b0;
    end
  end

endmodule : div_round

// ==== hdl/positioner_target_and_jerk_profile.sv ====
// Positioner target bookkeeping, position scaling and jerk-limited profile generator.
`timescale 1ns/1ps
//
// Behaviour
// [RULE_01] Scale all position quantities by units_per_count, user units per encoder count.
// [RULE_02] Accept moves, speeds, accelerations and corrections in user units only.
// [RULE_03] Keep target, setpoint, actual and tracking error, all readable by the host.
// [RULE_04] Actual position is encoder count scaled plus backlash, linear and map corrections.
// [RULE_05] Drive the servo loop with the theoretical commanded position, during and after moves.
// [RULE_06] Tracking error is the difference of commanded and actual positions.
// [RULE_07] Tracking error sign is commanded minus actual.
// [RULE_08] New final destination computed only for a command arriving while idle.
// [RULE_09] Absolute move takes the argument as the new final destination.
// [RULE_10] Relative move adds its length to the stored final destination.
// [RULE_11] Generator yields a theoretical position at every servo instant.
// [RULE_12] Profile uses the destination rounded to whole counts; tracking error rounded too.
// [RULE_13] Unrounded final destination is stored as reference for relative moves.
// [RULE_14] Round to nearest count, exact halves away from zero.
// [RULE_15] Host should use small incremental steps that are whole counts.
// [RULE_16] Acceleration is a parabola governed by the jerk time.
// [RULE_17] Jerk time chosen from step length, clamped between floor and ceiling.
// [RULE_18] Every move lasts at least four jerk times.
// [RULE_19] Hold speed, acceleration limit, emergency factor, jerk floor and ceiling.
// [RULE_20] Host may set speed, acceleration, jerk times; speed and accel below limits.
// [RULE_21] Run-time profile settings return to defaults after reset.
// [RULE_22] Reach the exact destination; cruise speed may deviate slightly.
// [RULE_23] On query, return displacement near request that meets set speed exactly.
`include "pos_params.svh"
module positioner_target_and_jerk_profile
  import motion_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Encoder and compensation
  input  wire logic [31:0] enc_count,
  input  wire logic [31:0] backlash_corr,
  input  wire logic [31:0] linear_corr,
  input  wire logic [31:0] map_corr,
  // Servo loop
  output logic             servo_tick,
  output logic      [31:0] commanded_theoretical_position,
  output logic      [31:0] tracking_error,
  output logic             moving
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [31:0] upc_r, speed_r, accel_r, jtf_r, jtc_r, vlim_r, alim_r, edf_r;
  fix_t        arg_r, fdest_r, rdest_r, actual_r, terr_r, qres_r, err_abs_r;
  wide_t       setp_r;
  logic [31:0] dist_r, jtraw_r, jt_r, tc_r, t_r;
  logic [47:0] vc_r, inv_r;
  logic        dir_r, query_r, refused_r, reject_r, qdone_r, err_neg_r;
  logic        ack_r, tick_r, tick_d_r;
  logic [31:0] dat_r;
  logic [11:0] tcnt_r;
  plan_state_e st_r, st_prev_r;

  div_if pd ();
  div_if ed ();

  div_round u_plan_div (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .d       (pd.server)
  );

  div_round u_err_div (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .d       (ed.server)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  logic        req, wr, idle;
  logic [31:0] wmask;
  logic [31:0] rd_data;
  logic        hit_ctrl, hit_status;

  assign req        = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr         = req & wb_we_i;
  assign wmask      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign idle       = (st_r == ST_IDLE);
  assign hit_ctrl   = wr & (wb_adr_i == `ADR_CTRL) & wb_sel_i[0];
  assign hit_status = wr & (wb_adr_i == `ADR_STATUS) & wb_sel_i[0];

  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~wmask) | (wb_dat_i & wmask);
  endfunction : merge

  function automatic logic wr_at(input logic [7:0] adr);
    return wr & (wb_adr_i == adr);
  endfunction : wr_at

  logic cmd_go, cmd_q, accept_move, accept_q, refuse_set;
  logic speed_ok, accel_ok;
  fix_t new_dest;

  assign cmd_go      = hit_ctrl & wb_dat_i[`CTRL_GO];
  assign cmd_q       = hit_ctrl & wb_dat_i[`CTRL_QRY] & ~wb_dat_i[`CTRL_GO];
  assign accept_move = cmd_go & idle; // RULE_08
  assign accept_q    = cmd_q & idle;
  assign refuse_set  = (cmd_go | cmd_q) & ~idle;
  assign new_dest    = wb_dat_i[`CTRL_REL] ? fdest_r + arg_r : arg_r; // RULE_09 RULE_10
  assign speed_ok    = (merge(speed_r) < vlim_r) & (merge(speed_r) != 32'h0); // RULE_20
  assign accel_ok    = (merge(accel_r) < alim_r) & (merge(accel_r) != 32'h0); // RULE_20

  logic [31:0] status;
  assign status = {28'h0, qdone_r, reject_r, refused_r, ~idle};

  assign rd_data = (wb_adr_i == `ADR_ARG)    ? arg_r :
                   (wb_adr_i == `ADR_UPC)    ? upc_r :
                   (wb_adr_i == `ADR_SPEED)  ? speed_r :
                   (wb_adr_i == `ADR_ACCEL)  ? accel_r :
                   (wb_adr_i == `ADR_JTF)    ? jtf_r :
                   (wb_adr_i == `ADR_JTC)    ? jtc_r :
                   (wb_adr_i == `ADR_VLIM)   ? vlim_r :
                   (wb_adr_i == `ADR_ALIM)   ? alim_r :
                   (wb_adr_i == `ADR_EDF)    ? edf_r :
                   (wb_adr_i == `ADR_FDEST)  ? fdest_r :
                   (wb_adr_i == `ADR_SETP)   ? setp_r[47:16] :
                   (wb_adr_i == `ADR_ACTUAL) ? actual_r :
                   (wb_adr_i == `ADR_TERR)   ? terr_r :
                   (wb_adr_i == `ADR_STATUS) ? status :
                   (wb_adr_i == `ADR_QRES)   ? qres_r :
                   (wb_adr_i == `ADR_JT)     ? jt_r :
                   (wb_adr_i == `ADR_CRUISE) ? vc_r[47:16] :
                   (wb_adr_i == `ADR_RDEST)  ? rdest_r :
                   32'h0; // RULE_03

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= req;
      dat_r <= (req & ~wb_we_i) ? rd_data : 32'h0;
    end
  end

  // ****************************************
  // Profile settings
  // ****************************************
  // Reset reloads the configured defaults, so run-time changes never survive a restart.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      speed_r <= `RST_SPEED; // RULE_21
      accel_r <= `RST_ACCEL; // RULE_21
      jtf_r   <= `RST_JTF; // RULE_21
      jtc_r   <= `RST_JTC; // RULE_21
      vlim_r  <= `RST_VLIM; // RULE_19
      alim_r  <= `RST_ALIM; // RULE_19
      edf_r   <= `RST_EDF; // RULE_19
      upc_r   <= `RST_UPC;
      arg_r   <= 32'sh0;
    end else begin
      if (wr_at(`ADR_SPEED) & speed_ok)
        speed_r <= merge(speed_r); // RULE_20
      if (wr_at(`ADR_ACCEL) & accel_ok)
        accel_r <= merge(accel_r); // RULE_20
      if (wr_at(`ADR_JTF))
        jtf_r <= merge(jtf_r);
      if (wr_at(`ADR_JTC))
        jtc_r <= merge(jtc_r);
      if (wr_at(`ADR_VLIM) & idle)
        vlim_r <= merge(vlim_r);
      if (wr_at(`ADR_ALIM) & idle)
        alim_r <= merge(alim_r);
      if (wr_at(`ADR_EDF))
        edf_r <= merge(edf_r);
      // The scale is frozen during a move so the profile keeps one unit grid.
      if (wr_at(`ADR_UPC) & idle)
        upc_r <= merge(upc_r); // RULE_01
      if (wr_at(`ADR_ARG))
        arg_r <= merge(arg_r); // RULE_02
    end
  end

  // Sticky flags clear by writing one; a simultaneous new event wins.
  logic rej_set;
  assign rej_set = (wr_at(`ADR_SPEED) & ~speed_ok) | (wr_at(`ADR_ACCEL) & ~accel_ok);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      refused_r <= 1'b0;
      reject_r  <= 1'b0;
      qdone_r   <= 1'b0;
    end else begin
      refused_r <= refuse_set | (refused_r & ~(hit_status & wb_dat_i[`STS_REFUSED]));
      reject_r  <= rej_set | (reject_r & ~(hit_status & wb_dat_i[`STS_REJECT]));
      qdone_r   <= (st_r == ST_TC & pd.done & query_r) |
                   (qdone_r & ~(hit_status & wb_dat_i[`STS_QDONE]));
    end
  end

  // ****************************************
  // Servo instant and position measurement
  // ****************************************
  logic [64:0] enc_prod;
  fix_t        err_raw;
  logic [63:0] terr_prod;

  assign enc_prod  = $signed(enc_count) * $signed({1'b0, upc_r}); // RULE_01
  assign err_raw   = setp_r[47:16] - actual_r; // RULE_06 RULE_07
  assign terr_prod = ed.quotient[31:0] * upc_r;
  assign ed.start    = tick_d_r;
  assign ed.rnd      = 1'b1;
  assign ed.dividend = {16'h0, err_abs_r};
  assign ed.divisor  = upc_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tcnt_r    <= 12'h0;
      tick_r    <= 1'b0;
      tick_d_r  <= 1'b0;
      actual_r  <= 32'sh0;
      err_abs_r <= 32'sh0;
      err_neg_r <= 1'b0;
      terr_r    <= 32'sh0;
    end else begin
      tick_r   <= (tcnt_r == 12'(`SERVO_DIV - 1));
      tcnt_r   <= (tcnt_r == 12'(`SERVO_DIV - 1)) ? 12'h0 : tcnt_r + 12'h1;
      tick_d_r <= tick_r;
      actual_r <= enc_prod[31:0] + backlash_corr + linear_corr + map_corr; // RULE_04
      if (tick_r) begin
        err_neg_r <= err_raw[31];
        err_abs_r <= err_raw[31] ? -err_raw : err_raw;
      end
      if (ed.done)
        terr_r <= err_neg_r ? -fix_t'(terr_prod[31:0]) : fix_t'(terr_prod[31:0]); // RULE_12
    end
  end

  // ****************************************
  // Move planning
  // ****************************************
  logic        fneg, start_div;
  fix_t        fabs, rdest_c, diff;
  logic [63:0] rnd_prod, q_prod;
  logic [31:0] pq, half, jt_min, floor1, jt_sel, jt_sel2, tc_sel, jt2, end_t;
  logic [33:0] speed3;

  assign pq       = pd.quotient[31:0];
  assign fneg     = fdest_r[31];
  assign fabs     = fneg ? -fdest_r : fdest_r;
  assign rnd_prod = pq * upc_r;
  assign rdest_c  = fneg ? -fix_t'(rnd_prod[31:0]) : fix_t'(rnd_prod[31:0]); // RULE_14
  assign diff     = rdest_c - setp_r[47:16];
  assign speed3   = {2'b0, speed_r} + {1'b0, speed_r, 1'b0};

  // Shorter steps shrink the jerk time toward half the linear move time.
  assign half    = {1'b0, pq[31:1]};
  assign jt_min  = (jtraw_r < half) ? jtraw_r : half; // RULE_17
  assign floor1  = (jtf_r == 32'h0) ? 32'h1 : jtf_r;
  assign jt_sel  = (jt_min < floor1) ? floor1 : (jt_min > jtc_r) ? jtc_r : jt_min; // RULE_17
  assign jt_sel2 = {jt_sel[30:0], 1'b0};
  assign tc_sel  = (pq > jt_sel2) ? pq - jt_sel2 : 32'h0;
  assign q_prod  = speed_r * (jt_sel2 + tc_sel); // RULE_23
  assign jt2     = {jt_r[30:0], 1'b0};
  assign end_t   = {jt_r[29:0], 2'b00} + tc_r; // RULE_18

  assign start_div   = (st_r != st_prev_r) & (st_r != ST_IDLE) & (st_r != ST_RUN);
  assign pd.start    = start_div;
  assign pd.rnd      = (st_r == ST_RND) | (st_r == ST_TC) | (st_r == ST_VEL);
  assign pd.dividend = (st_r == ST_RND) ? {16'h0, fabs} :
                       (st_r == ST_JT)  ? {14'h0, speed3} :
                       (st_r == ST_TC)  ? {16'h0, dist_r} :
                       (st_r == ST_VEL) ? {dist_r, 16'h0} :
                       48'h0001_0000_0000;
  assign pd.divisor  = (st_r == ST_RND) ? upc_r :
                       (st_r == ST_JT)  ? {accel_r[29:0], 2'b00} :
                       (st_r == ST_TC)  ? speed_r :
                       (st_r == ST_VEL) ? jt2 + tc_r :
                       jt2;

  // ****************************************
  // Profile generator
  // ****************************************
  // Speed follows a smoothstep, so acceleration is a parabola rising and falling over 2 jerk times.
  logic        ph_acc, ph_cru;
  logic [31:0] tl;
  logic [79:0] u_prod;
  logic [16:0] u, u2, ss, fac;
  logic [33:0] u_sq;
  logic [17:0] k;
  logic [34:0] ss_prod;
  logic [64:0] v_prod;
  wide_t       v;

  assign ph_acc  = (t_r < jt2);
  assign ph_cru  = ~ph_acc & (t_r < jt2 + tc_r);
  assign tl      = ph_acc ? t_r : t_r - jt2 - tc_r;
  assign u_prod  = tl * inv_r;
  assign u       = u_prod[32:16];
  assign u_sq    = u * u;
  assign u2      = u_sq[32:16];
  assign k       = 18'h3_0000 - {u, 1'b0};
  assign ss_prod = u2 * k;
  assign ss      = ss_prod[32:16]; // RULE_16
  assign fac     = ph_acc ? ss : ph_cru ? 17'h1_0000 : 17'h1_0000 - ss; // RULE_16
  assign v_prod  = vc_r * fac;
  assign v       = wide_t'(v_prod[63:16]);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r      <= ST_IDLE;
      st_prev_r <= ST_IDLE;
      fdest_r   <= 32'sh0;
      rdest_r   <= 32'sh0;
      setp_r    <= 48'sh0;
      dist_r    <= 32'h0;
      dir_r     <= 1'b0;
      query_r   <= 1'b0;
      qres_r    <= 32'sh0;
      jtraw_r   <= 32'h0;
      jt_r      <= 32'h0;
      tc_r      <= 32'h0;
      vc_r      <= 48'h0;
      inv_r     <= 48'h0;
      t_r       <= 32'h0;
    end else begin
      st_prev_r <= st_r;
      case (st_r)
        ST_IDLE: begin
          if (accept_move) begin
            fdest_r <= new_dest; // RULE_13
            query_r <= 1'b0;
            st_r    <= ST_RND;
          end else if (accept_q) begin
            dist_r  <= arg_r[31] ? -arg_r : arg_r;
            query_r <= 1'b1;
            st_r    <= ST_JT;
          end
        end
        ST_RND: begin
          if (pd.done) begin
            rdest_r <= rdest_c; // RULE_12
            dist_r  <= diff[31] ? -diff : diff;
            dir_r   <= diff[31];
            st_r    <= (diff == 32'sh0) ? ST_IDLE : ST_JT;
          end
        end
        ST_JT: begin
          if (pd.done) begin
            jtraw_r <= pq;
            st_r    <= ST_TC;
          end
        end
        ST_TC: begin
          if (pd.done) begin
            jt_r <= jt_sel;
            tc_r <= tc_sel;
            if (query_r) begin
              qres_r <= arg_r[31] ? -fix_t'(q_prod[31:0]) : fix_t'(q_prod[31:0]); // RULE_23
              st_r   <= ST_IDLE;
            end else begin
              st_r <= ST_VEL;
            end
          end
        end
        ST_VEL: begin
          if (pd.done) begin
            vc_r <= pd.quotient; // RULE_22
            st_r <= ST_INV;
          end
        end
        ST_INV: begin
          if (pd.done) begin
            inv_r <= pd.quotient;
            t_r   <= 32'h0;
            st_r  <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick_r) begin
            t_r <= t_r + 32'h1;
            if (t_r == end_t - 32'h1) begin
              setp_r <= {rdest_r, 16'h0}; // RULE_22
              st_r   <= ST_IDLE;
            end else begin
              setp_r <= dir_r ? setp_r - v : setp_r + v; // RULE_11
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign servo_tick                     = tick_r;
  assign commanded_theoretical_position = setp_r[47:16]; // RULE_05
  assign tracking_error                 = terr_r; // RULE_12
  assign moving                         = ~idle;

endmodule : positioner_target_and_jerk_profile

// ==== dv/pos_sva.sv ====
// Concurrent checks on the bus, servo tick and setpoint ports.
`timescale 1ns/1ps
`include "pos_params.svh"
module pos_sva (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Servo side
  input wire logic        servo_tick,
  input wire logic [31:0] commanded_theoretical_position,
  input wire logic [31:0] tracking_error,
  input wire logic        moving
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [15:0] gap_r;
  logic        seen_r;
  // The first tick after reset has no reference, hence the seen flag.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gap_r  <= 16'h0;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= servo_tick ? 16'h0 : gap_r + 16'h1;
      seen_r <= seen_r | servo_tick;
    end
  end
  property p_ack_follow; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_follow: assert property (p_ack_follow) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data without ack");
  property p_tick_gap; servo_tick && seen_r |-> gap_r == (`SERVO_DIV - 1); endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing");
  property p_setp_hold;
    !moving && !$past(moving) |-> $stable(commanded_theoretical_position);
  endproperty
  a_setp_hold: assert property (p_setp_hold) else $error("setpoint drift");
  property p_terr_time; $changed(tracking_error) |-> seen_r && gap_r < 16'h64; endproperty
  a_terr_time: assert property (p_terr_time) else $error("error update");
  property p_move_start; $rose(moving) |-> wb_ack_o || $past(wb_ack_o); endproperty
  a_move_start: assert property (p_move_start) else $error("move unasked");
  c_start: cover property ($rose(moving));
  c_end: cover property ($fell(moving));
  c_terr: cover property ($changed(tracking_error));
endmodule : pos_sva

bind positioner_target_and_jerk_profile pos_sva u_pos_sva (
  .sys_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
  .servo_tick, .commanded_theoretical_position, .tracking_error, .moving);

// ==== dv/servo_model.sv ====
// Servo loop and encoder model trailing the setpoint by a fixed count.
`timescale 1ns/1ps
module servo_model #(
  parameter int LAG = 1
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // From the positioner
  input  wire logic        servo_tick,
  input  wire logic [31:0] commanded_theoretical_position,
  // To the positioner
  output logic      [31:0] enc_count,
  output logic      [31:0] backlash_corr,
  output logic      [31:0] linear_corr,
  output logic      [31:0] map_corr
);
  // One user unit per count is assumed, so the count is the integer part.
  assign backlash_corr = 32'h0000_4000;
  assign linear_corr   = 32'h0000_2000;
  assign map_corr      = 32'h0000_0000;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      enc_count <= 32'h0;
    end else if (servo_tick) begin
      enc_count <= 32'($signed(commanded_theoretical_position) >>> 16) - 32'(LAG);
    end
  end
endmodule : servo_model

// ==== dv/positioner_target_and_jerk_profile_tb.sv ====
// Self-checking bench for the positioner target and profile block.
`timescale 1ns/1ps
`include "pos_params.svh"
module positioner_target_and_jerk_profile_tb;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, enc_count, backlash_corr, linear_corr, map_corr;
  logic [31:0] commanded_theoretical_position, tracking_error, rd;
  logic        wb_ack_o, servo_tick, moving;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc_n = 0;
  int          ticks = 0;
  always #12.5 sys_clk = ~sys_clk;
  positioner_target_and_jerk_profile u_positioner_target_and_jerk_profile (.sys_clk,
    .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .enc_count, .backlash_corr, .linear_corr, .map_corr, .servo_tick,
    .commanded_theoretical_position, .tracking_error, .moving);
  servo_model u_servo_model (.sys_clk, .resetn, .servo_tick, .commanded_theoretical_position,
    .enc_count, .backlash_corr, .linear_corr, .map_corr);
  // ****************
  // Helpers
  // ****************
  task automatic end_of_test;
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp32
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit
  // The request stays put until ack is seen at a rising edge.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp32(nm, e, rd);
  endtask : rdchk
  task automatic wait_bit(input int b, input logic v);
    do xfer(1'b0, `ADR_STATUS, 32'h0); while (rd[b] !== v);
  endtask : wait_bit
  task automatic move(input logic [31:0] arg, input logic [31:0] ctrl);
    wr(`ADR_ARG, arg);
    ticks = 0;
    wr(`ADR_CTRL, ctrl);
  endtask : move
  always @(posedge sys_clk) begin
    if (servo_tick === 1'b1 && moving === 1'b1) ticks++;
    cyc_n++;
    if (cyc_n == 100000) begin
      fails++;
      end_of_test;
    end
  end
  // ****************
  // Scenarios
  // ****************
  task automatic t_defaults;
    logic [7:0]  a [8] = '{`ADR_UPC, `ADR_SPEED, `ADR_ACCEL, `ADR_JTF, `ADR_JTC,
                           `ADR_VLIM, `ADR_ALIM, `ADR_EDF};
    logic [31:0] v [8] = '{`RST_UPC, `RST_SPEED, `RST_ACCEL, `RST_JTF, `RST_JTC,
                           `RST_VLIM, `RST_ALIM, `RST_EDF};
    for (int i = 0; i < 8; i++) rdchk("default", a[i], v[i]);
    rdchk("unmapped", 8'h4c, 32'h0);
  endtask : t_defaults
  task automatic t_reject;
    wr(`ADR_SPEED, `RST_VLIM);
    rdchk("speed", `ADR_SPEED, `RST_SPEED);
    xfer(1'b0, `ADR_STATUS, 32'h0);
    cmp_bit("reject", 1'b1, rd[`STS_REJECT]);
    wr(`ADR_STATUS, 32'h4);
    rdchk("status", `ADR_STATUS, 32'h0);
    wr(`ADR_ACCEL, 32'h0);
    rdchk("accel", `ADR_ACCEL, `RST_ACCEL);
    wait_bit(`STS_REJECT, 1'b1);
    wr(`ADR_STATUS, 32'h4);
  endtask : t_reject
  task automatic t_rel;
    wr(`ADR_UPC, 32'h0001_0000);
    wr(`ADR_SPEED, 32'h0000_ffff);
    wr(`ADR_ACCEL, 32'h0000_0fff);
    wr(`ADR_JTF, 32'h1);
    wr(`ADR_JTC, 32'h1);
    move(32'h0001_6666, 32'h3);
    wr(`ADR_CTRL, 32'h1);
    wait_bit(`STS_BUSY, 1'b0);
    cmp_bit("refused", 1'b1, rd[`STS_REFUSED]);
    cmp_bit("duration", 1'b1, ticks >= 4);
    rdchk("jerk", `ADR_JT, 32'h1);
    rdchk("setp", `ADR_SETP, 32'h0001_0000);
    rdchk("fdest", `ADR_FDEST, 32'h0001_6666);
    cmp32("setp_out", 32'h0001_0000, commanded_theoretical_position);
    wr(`ADR_STATUS, 32'h2);
    move(32'h0001_6666, 32'h3);
    wait_bit(`STS_BUSY, 1'b0);
    rdchk("setp", `ADR_SETP, 32'h0003_0000);
    rdchk("rdest", `ADR_RDEST, 32'h0003_0000);
    rdchk("fdest", `ADR_FDEST, 32'h0002_cccc);
  endtask : t_rel
  task automatic t_track;
    repeat (2) @(posedge servo_tick);
    repeat (100) @(posedge sys_clk);
    rdchk("actual", `ADR_ACTUAL, 32'h0002_6000);
    rdchk("terr", `ADR_TERR, 32'h0001_0000);
    cmp32("terr_out", 32'h0001_0000, tracking_error);
  endtask : t_track
  task automatic t_abs;
    move(32'hffff_8000, 32'h1);
    wait_bit(`STS_BUSY, 1'b0);
    rdchk("setp", `ADR_SETP, 32'hffff_0000);
    rdchk("fdest", `ADR_FDEST, 32'hffff_8000);
  endtask : t_abs
  task automatic t_query;
    move(32'h0001_0000, 32'h4);
    wait_bit(`STS_QDONE, 1'b1);
    rdchk("qres", `ADR_QRES, 32'h0001_fffe);
    rdchk("setp", `ADR_SETP, 32'hffff_0000);
  endtask : t_query
  task automatic t_reset;
    wr(`ADR_SPEED, 32'h0000_8000);
    rdchk("speed", `ADR_SPEED, 32'h0000_8000);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk("speed", `ADR_SPEED, `RST_SPEED);
    rdchk("upc", `ADR_UPC, `RST_UPC);
    rdchk("status", `ADR_STATUS, 32'h0);
  endtask : t_reset
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    t_defaults;
    t_reject;
    t_rel;
    t_track;
    t_abs;
    t_query;
    t_reset;
    end_of_test;
  end
endmodule : positioner_target_and_jerk_profile_tb
